// ==== inc/rx_cfg_pkg.sv ====
package rx_cfg_pkg;

   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [5:0] IDX_CHANNEL_FILTER = 6'h0A;
   localparam logic [5:0] IDX_AGC_SQUELCH = 6'h0B;
   localparam logic [5:0] IDX_FIRST_GAIN = 6'h0C;
   localparam logic [5:0] IDX_LATER_GAIN = 6'h0D;
   localparam logic [5:0] IDX_RX_STATUS = 6'h3F;

   // ------------------------------------------------------------
   // Values after power-up and after set-default
   // ------------------------------------------------------------
   localparam logic [7:0] RST_CHANNEL_FILTER = 8'h00;
   localparam logic [7:0] RST_AGC_SQUELCH = 8'h1A;
   localparam logic [7:0] RST_FIRST_GAIN = 8'hD8;
   localparam logic [7:0] RST_LATER_GAIN = 8'h00;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CHANNEL_CHOICE_BIT = 7;
   localparam int AM_DEMOD_MIXER_BIT = 6;
   localparam int LOW_PASS_LSB = 3;
   localparam int ZERO_SETTING_LSB = 0;
   localparam int RECEIVER_LOW_POWER_BIT = 7;
   localparam int LOW_FREQ_SPLIT_BIT = 6;
   localparam int LOW_FREQ_INPUT_ON_BIT = 5;
   localparam int AGC_ENABLE_BIT = 4;
   localparam int AGC_FULL_PERIOD_BIT = 3;
   localparam int AGC_RESET_ALG_BIT = 2;
   localparam int DYN_SQUELCH_BIT = 1;
   localparam int PM_MIXER_CLOCK_SRC_BIT = 0;
   localparam int AM_FIRST_GAIN_LSB = 5;
   localparam int PM_FIRST_GAIN_LSB = 2;
   localparam int CLIP_BIT = 1;
   localparam int FORCED_PEER_GAIN_BIT = 0;
   localparam int AM_LATER_GAIN_LSB = 4;
   localparam int PM_LATER_GAIN_LSB = 0;

   // ------------------------------------------------------------
   // Gain coding
   // ------------------------------------------------------------
   localparam logic [2:0] FIRST_BOOST_CODE = 3'h7;
   localparam logic [3:0] LATER_CODE_MAX = 4'hA;
   localparam logic [3:0] LATER_WINDOW_ONLY_MAX = 4'h4;
   localparam logic [2:0] WINDOW_MAX_STEPS = 3'h4;
   localparam logic [2:0] FORCED_STAGE_STEPS = 3'h2;

   // ------------------------------------------------------------
   // Squelch timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 10_000;
   localparam int SQUELCH_DELAY_PS = 18_880_000;
   localparam int SQUELCH_CYCLES = (SQUELCH_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SQUELCH_CNT_W = 11;
   localparam logic [SQUELCH_CNT_W-1:0] SQUELCH_LAST = SQUELCH_CNT_W'(SQUELCH_CYCLES - 1);

endpackage : rx_cfg_pkg

// ==== inc/rx_gain_if.sv ====
`timescale 1ns/100ps
// Carries one channel's later-stage gain code and its decoded steps
interface rx_gain_if;
   logic [3:0] code;
   logic [2:0] window_steps;
   logic [2:0] stage_steps;

   modport decoder (
      input code,
      output window_steps,
      output stage_steps
   );

   modport user (
      output code,
      input window_steps,
      input stage_steps
   );
endinterface : rx_gain_if

// ==== logic/later_gain_decode.sv ====
`timescale 1ns/100ps
module later_gain_decode
   import rx_cfg_pkg::*;
(
   rx_gain_if.decoder gain
);

   logic [3:0] clamped;

   // ------------------------------------------------------------
   // Code to window and stage steps
   // ------------------------------------------------------------
   // Unused codes above Ah act as Ah, so a stray write cannot overrange
   always_comb begin
      clamped = (gain.code > LATER_CODE_MAX) ? LATER_CODE_MAX : gain.code;
      if (clamped >= LATER_WINDOW_ONLY_MAX) begin
         gain.window_steps = WINDOW_MAX_STEPS;
      end else begin
         gain.window_steps = clamped[2:0];
      end
      if (clamped > LATER_WINDOW_ONLY_MAX) begin
         gain.stage_steps = 3'(clamped - LATER_WINDOW_ONLY_MAX);
      end else begin
         gain.stage_steps = 3'h0;
      end
   end

endmodule : later_gain_decode

// ==== logic/rx_cfg_regs.sv ====
`timescale 1ns/100ps
module rx_cfg_regs
   import rx_cfg_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Direct commands and receiver events
   input wire logic set_default_cmd_i,
   input wire logic reset_rx_gain_cmd_i,
   input wire logic receiver_restart_i,
   input wire logic tx_end_i,
   input wire logic mask_expire_i,
   input wire logic am_enable_i,
   input wire logic pm_enable_i,
   input wire logic manual_select_i,
   input wire logic auto_pm_i,
   input wire logic single_mode_i,
   // Receiver controls
   output logic channel_choice_o,
   output logic framing_pm_o,
   output logic am_demod_mixer_o,
   output logic [2:0] low_pass_ctl_o,
   output logic [2:0] zero_setting_o,
   output logic receiver_low_power_o,
   output logic low_freq_split_o,
   output logic low_freq_input_on_o,
   output logic agc_enable_o,
   output logic agc_full_period_o,
   output logic agc_reset_alg_o,
   output logic pm_mixer_internal_o,
   output logic [2:0] am_first_cut_steps_o,
   output logic am_first_boost_o,
   output logic [2:0] pm_first_cut_steps_o,
   output logic pm_first_boost_o,
   output logic clip_enable_o,
   output logic forced_peer_gain_o,
   output logic [2:0] am_window_steps_o,
   output logic [2:0] am_stage_steps_o,
   output logic [2:0] pm_window_steps_o,
   output logic [2:0] pm_stage_steps_o,
   output logic squelch_active_o,
   output logic restart_required_o
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] chan_filter;
      logic [7:0] agc_squelch;
      logic [7:0] first_gain;
      logic [7:0] later_gain;
      logic ack;
      logic [7:0] rdata;
      logic framing_pm;
      logic pm_mix_internal;
      logic [2:0] am_first_cut;
      logic am_first_boost;
      logic [2:0] pm_first_cut;
      logic pm_first_boost;
      logic [2:0] am_win_loaded;
      logic [2:0] am_stage_loaded;
      logic [2:0] pm_win_loaded;
      logic [2:0] pm_stage_loaded;
      logic [2:0] am_win;
      logic [2:0] am_stage;
      logic [2:0] pm_win;
      logic [2:0] pm_stage;
      logic restart_req;
   } state_type;

   state_type s_ff;
   state_type nxt_s;

   logic bus_req;
   logic wr_lo;
   logic sq_active;
   logic forced;
   logic [7:0] status;

   rx_gain_if am_gain ();
   rx_gain_if pm_gain ();

   // ------------------------------------------------------------
   // Later-stage decoders and squelch timer
   // ------------------------------------------------------------
   // Decoders read the stored register; results only matter when loaded
   assign am_gain.code = s_ff.later_gain[AM_LATER_GAIN_LSB +: 4];
   assign pm_gain.code = s_ff.later_gain[PM_LATER_GAIN_LSB +: 4];

   later_gain_decode u_am_decode (
      .gain (am_gain)
   );

   later_gain_decode u_pm_decode (
      .gain (pm_gain)
   );

   squelch_timer u_squelch (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .enable_i (s_ff.agc_squelch[DYN_SQUELCH_BIT]),
      .tx_end_i (tx_end_i),
      .mask_expire_i (mask_expire_i),
      .active_o (sq_active)
   );

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   // One wait state: ack rises the cycle after the request, then drops
   assign bus_req = cyc_i && stb_i && !s_ff.ack;
   assign wr_lo = bus_req && we_i && sel_i[0];
   assign forced = s_ff.first_gain[FORCED_PEER_GAIN_BIT];
   assign status = {6'h00, s_ff.restart_req, sq_active};

   // Read mux only selects; nothing in it changes receiver state
   function automatic logic [7:0] read_mux(input logic [5:0] idx, input state_type st,
                                           input logic [7:0] stat);
      logic [7:0] val;
      val = 8'h00;
      unique case (idx)
         IDX_CHANNEL_FILTER: val = st.chan_filter;
         IDX_AGC_SQUELCH: val = st.agc_squelch;
         IDX_FIRST_GAIN: val = st.first_gain;
         IDX_LATER_GAIN: val = st.later_gain;
         IDX_RX_STATUS: val = stat;
         default: val = 8'h00;
      endcase
      return val;
   endfunction : read_mux

   // First-stage code to cut steps and boost flag
   function automatic logic [3:0] first_decode(input logic [2:0] code);
      logic [3:0] res;
      res = 4'h0;
      if (code == FIRST_BOOST_CODE) begin
         res = 4'h8;
      end else begin
         res = {1'b0, code};
      end
      return res;
   endfunction : first_decode

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      nxt_s = s_ff;
      nxt_s.ack = bus_req;
      if (bus_req && !we_i) begin
         nxt_s.rdata = read_mux(adr_i[7:2], s_ff, status);
      end

      // Register writes; unmapped or misaligned writes are dropped
      if (wr_lo && (adr_i[1:0] == 2'b00)) begin
         unique case (adr_i[7:2])
            IDX_CHANNEL_FILTER: nxt_s.chan_filter = dat_i[7:0];
            IDX_AGC_SQUELCH: nxt_s.agc_squelch = dat_i[7:0];
            IDX_FIRST_GAIN: nxt_s.first_gain = dat_i[7:0];
            IDX_LATER_GAIN: nxt_s.later_gain = dat_i[7:0];
            default: nxt_s.later_gain = s_ff.later_gain;
         endcase
      end

      // Set-default beats a write in the same cycle
      if (set_default_cmd_i) begin
         nxt_s.chan_filter = RST_CHANNEL_FILTER;
         nxt_s.agc_squelch = RST_AGC_SQUELCH;
         nxt_s.first_gain = RST_FIRST_GAIN;
         nxt_s.later_gain = RST_LATER_GAIN;
      end

      // Later-stage settings travel onward only on the reset-gain command
      if (reset_rx_gain_cmd_i) begin
         nxt_s.am_win_loaded = am_gain.window_steps;
         nxt_s.am_stage_loaded = am_gain.stage_steps;
         nxt_s.pm_win_loaded = pm_gain.window_steps;
         nxt_s.pm_stage_loaded = pm_gain.stage_steps;
      end

      // Forced gain overrides the loaded settings while set
      if (forced) begin
         nxt_s.am_win = WINDOW_MAX_STEPS;
         nxt_s.am_stage = FORCED_STAGE_STEPS;
         nxt_s.pm_win = WINDOW_MAX_STEPS;
         nxt_s.pm_stage = FORCED_STAGE_STEPS;
      end else begin
         nxt_s.am_win = s_ff.am_win_loaded;
         nxt_s.am_stage = s_ff.am_stage_loaded;
         nxt_s.pm_win = s_ff.pm_win_loaded;
         nxt_s.pm_stage = s_ff.pm_stage_loaded;
      end

      // Clearing forced gain leaves the analog path stale until a restart;
      // a new clear in the restart cycle wins so it is never lost
      if (receiver_restart_i) begin
         nxt_s.restart_req = 1'b0;
      end
      if (forced && !nxt_s.first_gain[FORCED_PEER_GAIN_BIT]) begin
         nxt_s.restart_req = 1'b1;
      end

      // Channel steering
      if (am_enable_i && pm_enable_i) begin
         nxt_s.framing_pm = manual_select_i ? s_ff.chan_filter[CHANNEL_CHOICE_BIT]
                                            : auto_pm_i;
      end else begin
         nxt_s.framing_pm = s_ff.chan_filter[CHANNEL_CHOICE_BIT];
      end

      // Single mode has no usable driver phase, so internal clock is forced
      nxt_s.pm_mix_internal = s_ff.agc_squelch[PM_MIXER_CLOCK_SRC_BIT]
                              || single_mode_i;

      {nxt_s.am_first_boost, nxt_s.am_first_cut} =
         first_decode(s_ff.first_gain[AM_FIRST_GAIN_LSB +: 3]);
      {nxt_s.pm_first_boost, nxt_s.pm_first_cut} =
         first_decode(s_ff.first_gain[PM_FIRST_GAIN_LSB +: 3]);
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_ff <= '0;
         s_ff.chan_filter <= RST_CHANNEL_FILTER;
         s_ff.agc_squelch <= RST_AGC_SQUELCH;
         s_ff.first_gain <= RST_FIRST_GAIN;
         s_ff.later_gain <= RST_LATER_GAIN;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ------------------------------------------------------------
   // Outputs, all from flip-flops
   // ------------------------------------------------------------
   assign dat_o = {24'h000000, s_ff.rdata};
   assign ack_o = s_ff.ack;

   // Fields that steer analog blocks directly
   assign channel_choice_o = s_ff.chan_filter[CHANNEL_CHOICE_BIT];
   assign framing_pm_o = s_ff.framing_pm;
   assign am_demod_mixer_o = s_ff.chan_filter[AM_DEMOD_MIXER_BIT];
   assign low_pass_ctl_o = s_ff.chan_filter[LOW_PASS_LSB +: 3];
   assign zero_setting_o = s_ff.chan_filter[ZERO_SETTING_LSB +: 3];
   assign receiver_low_power_o = s_ff.agc_squelch[RECEIVER_LOW_POWER_BIT];
   assign low_freq_split_o = s_ff.agc_squelch[LOW_FREQ_SPLIT_BIT];
   assign low_freq_input_on_o = s_ff.agc_squelch[LOW_FREQ_INPUT_ON_BIT];
   assign agc_enable_o = s_ff.agc_squelch[AGC_ENABLE_BIT];
   assign agc_full_period_o = s_ff.agc_squelch[AGC_FULL_PERIOD_BIT];
   assign agc_reset_alg_o = s_ff.agc_squelch[AGC_RESET_ALG_BIT];
   assign pm_mixer_internal_o = s_ff.pm_mix_internal;
   assign clip_enable_o = s_ff.first_gain[CLIP_BIT];
   assign forced_peer_gain_o = forced;

   // Decoded gains
   assign am_first_cut_steps_o = s_ff.am_first_cut;
   assign am_first_boost_o = s_ff.am_first_boost;
   assign pm_first_cut_steps_o = s_ff.pm_first_cut;
   assign pm_first_boost_o = s_ff.pm_first_boost;
   assign am_window_steps_o = s_ff.am_win;
   assign am_stage_steps_o = s_ff.am_stage;
   assign pm_window_steps_o = s_ff.pm_win;
   assign pm_stage_steps_o = s_ff.pm_stage;

   // Receiver status
   assign squelch_active_o = sq_active;
   assign restart_required_o = s_ff.restart_req;

endmodule : rx_cfg_regs

// ==== logic/squelch_timer.sv ====
`timescale 1ns/100ps
module squelch_timer
   import rx_cfg_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic enable_i,
   input wire logic tx_end_i,
   input wire logic mask_expire_i,
   output logic active_o
);

   typedef struct packed {
      logic waiting;
      logic active;
      logic [SQUELCH_CNT_W-1:0] cnt;
   } sq_state_type;

   sq_state_type sq_ff;
   sq_state_type nxt_sq;

   // ------------------------------------------------------------
   // Delay after end of transmit, then hold until mask expiry or until dynamic squelch is disabled
   // ------------------------------------------------------------
   always_comb begin
      nxt_sq = sq_ff;
      if (sq_ff.waiting) begin
         if (sq_ff.cnt == SQUELCH_LAST) begin
            nxt_sq.waiting = 1'b0;
            nxt_sq.active = 1'b1;
         end else begin
            nxt_sq.cnt = SQUELCH_CNT_W'(sq_ff.cnt + 1'b1);
         end
      end
      // Expiry ends squelch; an early expiry also cancels the pending start
      if (mask_expire_i) begin
         nxt_sq.waiting = 1'b0;
         nxt_sq.active = 1'b0;
      end
      if (tx_end_i && enable_i) begin
         nxt_sq.waiting = 1'b1;
         nxt_sq.cnt = '0;
      end
      if (!enable_i) begin
         nxt_sq.waiting = 1'b0;
         nxt_sq.active = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sq_ff <= '0;
      end else begin
         sq_ff <= nxt_sq;
      end
   end

   assign active_o = sq_ff.active;

endmodule : squelch_timer

// ==== verif/rx_cfg_regs_monitor.sv ====
`timescale 1ns/100ps
module rx_cfg_regs_monitor
   import rx_cfg_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic set_default_cmd_i,
   input wire logic tx_end_i,
   input wire logic mask_expire_i,
   input wire logic am_enable_i,
   input wire logic pm_enable_i,
   input wire logic single_mode_i,
   input wire logic channel_choice_o,
   input wire logic framing_pm_o,
   input wire logic pm_mixer_internal_o,
   input wire logic agc_enable_o,
   input wire logic agc_full_period_o,
   input wire logic forced_peer_gain_o,
   input wire logic [2:0] pm_window_steps_o,
   input wire logic [2:0] pm_stage_steps_o,
   input wire logic squelch_active_o,
   input wire logic restart_required_o
);
   // ------------------------------------------------------------
   // Cycles since the last end of transmit
   // ------------------------------------------------------------
   logic [11:0] since_tx_ff;
   logic [11:0] nxt_since_tx;

   // Saturates so a stale count never wraps into the legal window
   always_comb begin
      nxt_since_tx = since_tx_ff;
      if (tx_end_i) begin
         nxt_since_tx = 12'h001;
      end else if (since_tx_ff != 12'hFFF) begin
         nxt_since_tx = since_tx_ff + 12'h001;
      end
   end

   always_ff @(posedge clk_i) begin
      since_tx_ff <= rst_i ? 12'hFFF : nxt_since_tx;
   end

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   bus_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("bus request not acknowledged in one cycle");
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("acknowledge longer than one cycle");
   default_load_a: assert property (set_default_cmd_i |=>
      agc_enable_o && agc_full_period_o && !channel_choice_o && !forced_peer_gain_o)
      else $error("set-default did not restore fields");
   forced_window_a: assert property (forced_peer_gain_o [*2] |->
      pm_window_steps_o == 3'h4 && pm_stage_steps_o == 3'h2)
      else $error("forced gain not applied");
   restart_flag_a: assert property ($fell(forced_peer_gain_o) |-> ##[0:1] restart_required_o)
      else $error("restart flag not raised");
   squelch_end_a: assert property (mask_expire_i |=> !squelch_active_o)
      else $error("squelch kept after mask expiry");
   squelch_delay_a: assert property ($rose(squelch_active_o) |->
      since_tx_ff >= 12'(SQUELCH_CYCLES) && since_tx_ff <= 12'(SQUELCH_CYCLES + 2))
      else $error("squelch rose at wrong delay");
   mixer_single_a: assert property (single_mode_i |=> pm_mixer_internal_o)
      else $error("single mode did not force internal mixer clock");
   framing_one_a: assert property (am_enable_i != pm_enable_i |=>
      framing_pm_o == $past(channel_choice_o))
      else $error("framing channel differs from choice bit");
endmodule : rx_cfg_regs_monitor

bind rx_cfg_regs rx_cfg_regs_monitor rx_cfg_regs_monitor_inst (.*);

// ==== verif/rx_cfg_regs_test.sv ====
`timescale 1ns/100ps
module rx_cfg_regs_test;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0;
   logic [3:0] sel_i = 4'h0;
   logic we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
   logic [4:0] cmd = 5'h00;
   logic am_enable_i = 1'b1, pm_enable_i = 1'b0, manual_select_i = 1'b1;
   logic auto_pm_i = 1'b0, single_mode_i = 1'b0;
   logic [31:0] dat_o;
   logic ack_o, channel_choice_o, framing_pm_o, am_demod_mixer_o, receiver_low_power_o;
   logic low_freq_split_o, low_freq_input_on_o, agc_enable_o, agc_full_period_o;
   logic agc_reset_alg_o, pm_mixer_internal_o, am_first_boost_o, pm_first_boost_o;
   logic clip_enable_o, forced_peer_gain_o, squelch_active_o, restart_required_o;
   logic [2:0] low_pass_ctl_o, zero_setting_o, am_first_cut_steps_o, pm_first_cut_steps_o;
   logic [2:0] am_window_steps_o, am_stage_steps_o, pm_window_steps_o, pm_stage_steps_o;
   logic [7:0] rd;
   logic [7:0] dv [4] = '{8'h00, 8'h1A, 8'hD8, 8'h00};
   int err_count = 0, compares = 0, cycles = 0;

   // Commands: default, gain load, restart, end of transmit, mask expiry
   rx_cfg_regs rx_cfg_regs_inst (
      .*,
      .set_default_cmd_i(cmd[0]),
      .reset_rx_gain_cmd_i(cmd[1]),
      .receiver_restart_i(cmd[2]),
      .tx_end_i(cmd[3]),
      .mask_expire_i(cmd[4])
   );

   initial begin
      forever #5 clk_i = ~clk_i;
   end

   // Squelch wait dominates; ceiling leaves ample margin
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         err_count++;
         final_report;
      end
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task check(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: saw %h, expected %h", $time, got, exp);
      end
   endtask : check

   task idle(input int n);
      repeat (n) @(posedge clk_i);
   endtask : idle

   // One classic cycle; held until ack is sampled high
   task wb(input logic [7:0] a, input logic [7:0] d, input logic w);
      @(posedge clk_i);
      adr_i <= a;
      dat_i <= {24'h0, d};
      we_i <= w;
      sel_i <= 4'h1;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      // No local limit: only the bench timeout ends a hung wait
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      rd = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask : wb

   task pulse(input int b);
      @(posedge clk_i);
      cmd[b] <= 1'b1;
      @(posedge clk_i);
      cmd[b] <= 1'b0;
   endtask : pulse

   task chk_defaults;
      for (int i = 0; i < 4; i++) begin
         wb(8'h28 + 8'(4 * i), 8'h00, 1'b0);
         check(rd, dv[i]);
      end
   endtask : chk_defaults

   function logic [2:0] win(input logic [3:0] c);
      return (c > 4'h4) ? 3'h4 : c[2:0];
   endfunction : win

   function logic [2:0] stg(input logic [3:0] c);
      return (c > 4'hA) ? 3'h6 : (c > 4'h4) ? 3'(c - 4'h4) : 3'h0;
   endfunction : stg

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_reset;
      chk_defaults;
      check(agc_enable_o, 8'h01);
      check(agc_full_period_o, 8'h01);
      check(am_first_cut_steps_o, 8'h06);
      $display("reset defaults test done");
   endtask : t_reset

   task t_fields;
      wb(8'h28, 8'hA5, 1'b1);
      idle(1);
      check(channel_choice_o, 8'h01);
      check(am_demod_mixer_o, 8'h00);
      check({low_pass_ctl_o, zero_setting_o}, 8'h25);
      wb(8'h28, 8'h5A, 1'b1);
      wb(8'h2C, 8'hE5, 1'b1);
      idle(2);
      check(am_demod_mixer_o, 8'h01);
      check({low_pass_ctl_o, zero_setting_o}, 8'h1A);
      check({receiver_low_power_o, low_freq_split_o, low_freq_input_on_o}, 8'h07);
      check({agc_enable_o, agc_full_period_o, agc_reset_alg_o}, 8'h01);
      check(pm_mixer_internal_o, 8'h01);
      wb(8'h2C, 8'h1A, 1'b1);
      idle(2);
      check({receiver_low_power_o, pm_mixer_internal_o}, 8'h00);
      single_mode_i <= 1'b1;
      idle(3);
      check(pm_mixer_internal_o, 8'h01);
      single_mode_i <= 1'b0;
      wb(8'h40, 8'hFF, 1'b1);
      wb(8'h40, 8'h00, 1'b0);
      check(rd, 8'h00);
      wb(8'h28, 8'h00, 1'b0);
      check(rd, 8'h5A);
      $display("field mapping test done");
   endtask : t_fields

   task t_first;
      logic [2:0] c, p;
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         p = ~c;
         wb(8'h30, {c, ~c, 2'b10}, 1'b1);
         idle(2);
         check({am_first_boost_o, am_first_cut_steps_o}, (c == 3'h7) ? 8'h08 : c);
         check({pm_first_boost_o, pm_first_cut_steps_o}, (p == 3'h7) ? 8'h08 : p);
         check(clip_enable_o, 8'h01);
      end
      $display("first stage gain test done");
   endtask : t_first

   task t_later;
      logic [3:0] c, pa, pp;
      pa = 4'h0;
      pp = 4'h0;
      for (int i = 0; i < 16; i++) begin
         c = 4'(i);
         wb(8'h34, {c, ~c}, 1'b1);
         idle(2);
         check({am_window_steps_o, pm_stage_steps_o}, {win(pa), stg(pp)});
         pulse(1);
         // Loaded one edge after the command, outputs one edge later
         idle(2);
         check({am_window_steps_o, am_stage_steps_o}, {win(c), stg(c)});
         check({pm_window_steps_o, pm_stage_steps_o}, {win(~c), stg(~c)});
         pa = c;
         pp = ~c;
      end
      $display("later stage gain test done");
   endtask : t_later

   task t_forced;
      wb(8'h30, 8'hD9, 1'b1);
      idle(2);
      check({am_window_steps_o, am_stage_steps_o}, 8'h22);
      check({pm_window_steps_o, pm_stage_steps_o}, 8'h22);
      wb(8'h30, 8'hD8, 1'b1);
      idle(2);
      check(restart_required_o, 8'h01);
      check(pm_window_steps_o, 8'h00);
      wb(8'hFC, 8'h00, 1'b0);
      check(rd, 8'h02);
      pulse(2);
      idle(1);
      check(restart_required_o, 8'h00);
      $display("forced gain test done");
   endtask : t_forced

   // Choice bit loses to the automatic pick only when both channels run
   task t_frame;
      wb(8'h28, 8'h80, 1'b1);
      idle(2);
      check(framing_pm_o, 8'h01);
      pm_enable_i <= 1'b1;
      manual_select_i <= 1'b0;
      idle(3);
      check(framing_pm_o, 8'h00);
      auto_pm_i <= 1'b1;
      idle(3);
      check(framing_pm_o, 8'h01);
      manual_select_i <= 1'b1;
      auto_pm_i <= 1'b0;
      idle(3);
      check(framing_pm_o, 8'h01);
      pm_enable_i <= 1'b0;
      $display("framing channel test done");
   endtask : t_frame

   task t_default;
      wb(8'h2C, 8'hE5, 1'b1);
      wb(8'h34, 8'h55, 1'b1);
      pulse(0);
      idle(1);
      chk_defaults;
      $display("set default test done");
   endtask : t_default

   task t_squelch;
      int n;
      pulse(3);
      n = 0;
      while (squelch_active_o !== 1'b1 && n < 2100) begin
         @(posedge clk_i);
         n++;
      end
      check((n == 1888 || n == 1889) ? 8'h01 : 8'h00, 8'h01);
      wb(8'hFC, 8'h00, 1'b0);
      check(rd, 8'h01);
      pulse(4);
      idle(1);
      check(squelch_active_o, 8'h00);
      wb(8'h2C, 8'h18, 1'b1);
      pulse(3);
      idle(1900);
      check(squelch_active_o, 8'h00);
      $display("squelch test done");
   endtask : t_squelch

   task final_report;
      $display("Comparisons %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report

   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_fields;
      t_first;
      t_later;
      t_forced;
      t_frame;
      t_default;
      t_squelch;
      final_report;
   end
endmodule : rx_cfg_regs_test
